// file: hw/io_stop_pkg.sv
// Purpose: shared constants and carriers for the io/stop/status block
// Assumes: 40 MHz reference clock
// Notes: register map is a plain address/strobe port
package io_stop_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned SLOW_FLASH_MS = 500;
  localparam int unsigned FAST_FLASH_MS = 100;
  localparam int unsigned SLOW_FLASH_CYC = CLK_HZ / 1000 * SLOW_FLASH_MS;
  localparam int unsigned FAST_FLASH_CYC = CLK_HZ / 1000 * FAST_FLASH_MS;
  localparam int unsigned ADC_BITS = 12;
  localparam logic [ADC_BITS-1:0] ADC_MAX = 12'hFFF;
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_INPUTS = 4'h1;
  localparam logic [ADDR_W-1:0] REG_ANALOG = 4'h2;
  localparam logic [ADDR_W-1:0] REG_ENC = 4'h3;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h4;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h5;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h6;
  // ctrl fields
  localparam int unsigned CTRL_PU_HOME = 0;
  localparam int unsigned CTRL_PU_AB = 1;
  localparam int unsigned CTRL_OUT = 2;
  localparam int unsigned CTRL_STOP_L_EN = 3;
  localparam int unsigned CTRL_STOP_R_EN = 4;
  localparam int unsigned CTRL_ISO_STEPDIR = 5;
  localparam int unsigned CTRL_AB_ENC = 6;
  localparam int unsigned CTRL_HOME_DIG = 7;
  localparam int unsigned CTRL_FW_VALID = 8;
  localparam int unsigned CTRL_FW_UPDATE = 9;
  localparam int unsigned CTRL_RESTORE_DONE = 10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
  // irq bits
  localparam int unsigned IRQ_W = 5;
  localparam int unsigned IRQ_STOP_L = 0;
  localparam int unsigned IRQ_STOP_R = 1;
  localparam int unsigned IRQ_HOME = 2;
  localparam int unsigned IRQ_USB = 3;
  localparam int unsigned IRQ_ENC_ERR = 4;
  typedef enum logic [1:0] {
    LED_RUN = 2'b00,
    LED_RESTORE = 2'b01,
    LED_BOOT = 2'b11
  } led_mode_t;
  typedef struct packed {
    logic step;
    logic dir;
  } motion_cmd_t;
  typedef struct packed {
    logic red;
    logic green;
  } led_pair_t;
endpackage : io_stop_pkg

// file: hw/io_stop_status_logic.sv
// Purpose: multi-purpose inputs, stop gating, open-drain output, leds, restore strap
// Assumes: pins are asynchronous and pass a two-flop synchroniser
// Notes: adc samples arrive already on this clock
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - usb attach present forces can interface disabled.
// - analog/home input usable both ways with its own pull-up control.
// - one pull-up control drives both general inputs, on after reset.
// - open-drain output pulls low when active, released otherwise.
// - 12-bit conversion result, 0..4095, saturates above range.
// - left stop enabled and active blocks negative-direction steps.
// - right stop enabled and active blocks positive-direction steps.
// - isolated inputs act as stop switches or external step/direction.
// - general inputs decode a quadrature a/b encoder.
// - normal firmware: green flashes slowly, red off.
// - no valid firmware or updating: red and green both lit.
// - factory restore in progress: green flashes fast.
// - pads shorted at power-on start a factory restore.
// - after restore, next power-up with pads open uses defaults.
module io_stop_status_logic
  import io_stop_pkg::*;
#(
  parameter int unsigned SLOW_CYC = io_stop_pkg::SLOW_FLASH_CYC,
  parameter int unsigned FAST_CYC = io_stop_pkg::FAST_FLASH_CYC
) (
  input wire logic i_ref_clk, // 40 MHz clock
  input wire logic i_reset, // async reset, active high
  input wire logic [io_stop_pkg::ADDR_W-1:0] i_addr, // register address
  input wire logic [31:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [31:0] o_rdata, // read data, cycle after strobe
  input wire logic i_analog_home_input, // digital view of analog/home pin
  input wire logic [io_stop_pkg::ADC_BITS:0] i_adc_raw, // raw conversion, extra top bit
  input wire logic i_general_input_a, // general input a / quad a
  input wire logic i_general_input_b, // general input b / quad b
  input wire logic i_iso_left, // isolated stop left / step
  input wire logic i_iso_right, // isolated stop right / dir
  input wire logic i_usb_attached, // usb vbus present
  input wire logic i_debug_data_pad, // pad shorted to clock pad, low = shorted
  input wire io_stop_pkg::motion_cmd_t i_int_cmd, // internal step/dir from ramp
  output io_stop_pkg::motion_cmd_t o_motor_cmd, // gated step/dir to driver
  output logic o_can_enable, // can transceiver enable
  output logic o_pu_home, // pull-up enable for analog/home pin
  output logic o_pu_general, // shared pull-up for general inputs
  output logic o_open_drain_output, // pin drive value (always low)
  output logic o_open_drain_output_oe, // pin output enable
  output logic o_restore_active, // factory restore running
  output io_stop_pkg::led_pair_t o_led, // status leds
  output logic o_irq // level interrupt
);
  import io_stop_pkg::*;

  // two-flop synchronisers for all pin inputs
  localparam int unsigned NSYNC = 7;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  assign pin_raw = {i_debug_data_pad, i_usb_attached, i_iso_right, i_iso_left,
                    i_general_input_b, i_general_input_a, i_analog_home_input};
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end
  logic home_s, quad_a, quad_b, iso_l, iso_r, usb_s, pad_s;
  assign {pad_s, usb_s, iso_r, iso_l, quad_b, quad_a, home_s} = sync2_q;

  // control register
  logic [31:0] ctrl_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic wr_ctrl;
  assign wr_ctrl = i_wr && (i_addr == REG_CTRL);
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= i_wdata;
    end
  end

  // pull-ups and open-drain output
  assign o_pu_home = ctrl_q[CTRL_PU_HOME];
  assign o_pu_general = ctrl_q[CTRL_PU_AB];
  assign o_open_drain_output = 1'b0;
  assign o_open_drain_output_oe = ctrl_q[CTRL_OUT];
  // can off while usb present
  assign o_can_enable = !usb_s;

  // adc saturation
  logic [ADC_BITS-1:0] adc_q;
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      adc_q <= '0;
    end else begin
      adc_q <= i_adc_raw[ADC_BITS] ? ADC_MAX : i_adc_raw[ADC_BITS-1:0];
    end
  end

  // role selection for isolated inputs
  logic stepdir_mode;
  logic stop_l_act, stop_r_act;
  motion_cmd_t src_cmd;
  assign stepdir_mode = ctrl_q[CTRL_ISO_STEPDIR];
  assign stop_l_act = !stepdir_mode && ctrl_q[CTRL_STOP_L_EN] && iso_l;
  assign stop_r_act = !stepdir_mode && ctrl_q[CTRL_STOP_R_EN] && iso_r;
  assign src_cmd = stepdir_mode ? motion_cmd_t'{step: iso_l, dir: iso_r} : i_int_cmd;

  // direction-gated step; dir=1 positive, dir=0 negative
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_motor_cmd <= '0;
    end else begin
      o_motor_cmd.dir <= src_cmd.dir;
      o_motor_cmd.step <= src_cmd.step
        && !(stop_l_act && !src_cmd.dir)
        && !(stop_r_act && src_cmd.dir);
    end
  end

  // quadrature decoder on general inputs
  logic [1:0] ab_q;
  logic [31:0] enc_cnt_q;
  logic enc_en, enc_err;
  assign enc_en = ctrl_q[CTRL_AB_ENC];
  assign enc_err = enc_en && (ab_q[0] != quad_a) && (ab_q[1] != quad_b);
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      ab_q <= '0;
      enc_cnt_q <= '0;
    end else begin
      ab_q <= {quad_b, quad_a};
      if (enc_en && !enc_err) begin
        if (ab_q[0] != quad_a) begin
          enc_cnt_q <= (quad_a != quad_b) ? enc_cnt_q + 32'h1 : enc_cnt_q - 32'h1;
        end else if (ab_q[1] != quad_b) begin
          enc_cnt_q <= (quad_a == quad_b) ? enc_cnt_q + 32'h1 : enc_cnt_q - 32'h1;
        end
      end
    end
  end

  // factory restore strap caught once the synchroniser holds the real pad level,
  // since its reset value would otherwise read as a shorted pad
  logic [1:0] strap_wait_q;
  logic strap_seen_q;
  logic restore_q;
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      strap_wait_q <= '0;
      strap_seen_q <= 1'b0;
      restore_q <= 1'b0;
    end else if (!strap_seen_q) begin
      strap_wait_q <= {strap_wait_q[0], 1'b1};
      if (strap_wait_q[1]) begin
        strap_seen_q <= 1'b1;
        restore_q <= !pad_s;
      end
    end else if (wr_ctrl && i_wdata[CTRL_RESTORE_DONE]) begin
      restore_q <= 1'b0;
    end
  end
  assign o_restore_active = restore_q;

  // led mode and flasher
  led_mode_t led_mode;
  logic [31:0] flash_cnt_q;
  logic flash_q;
  logic [31:0] flash_lim;
  always_comb begin
    if (restore_q) begin
      led_mode = LED_RESTORE;
    end else if (!ctrl_q[CTRL_FW_VALID] || ctrl_q[CTRL_FW_UPDATE]) begin
      led_mode = LED_BOOT;
    end else begin
      led_mode = LED_RUN;
    end
  end
  assign flash_lim = (led_mode == LED_RESTORE) ? 32'(FAST_CYC - 1) : 32'(SLOW_CYC - 1);
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      flash_cnt_q <= '0;
      flash_q <= 1'b0;
    end else if (flash_cnt_q >= flash_lim) begin
      flash_cnt_q <= '0;
      flash_q <= !flash_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + 32'h1;
    end
  end
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_led <= '0;
    end else begin
      unique case (led_mode)
        LED_RUN: o_led <= '{red: 1'b0, green: flash_q};
        LED_BOOT: o_led <= '{red: 1'b1, green: 1'b1};
        LED_RESTORE: o_led <= '{red: 1'b0, green: flash_q};
        default: o_led <= '0;
      endcase
    end
  end

  // interrupt status: set wins over write-one-to-clear
  logic [IRQ_W-1:0] ev;
  logic home_q, usb_q, sl_q, sr_q;
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      home_q <= 1'b0;
      usb_q <= 1'b0;
      sl_q <= 1'b0;
      sr_q <= 1'b0;
    end else begin
      home_q <= home_s;
      usb_q <= usb_s;
      sl_q <= stop_l_act;
      sr_q <= stop_r_act;
    end
  end
  always_comb begin
    ev = '0;
    ev[IRQ_STOP_L] = stop_l_act && !sl_q;
    ev[IRQ_STOP_R] = stop_r_act && !sr_q;
    ev[IRQ_HOME] = ctrl_q[CTRL_HOME_DIG] && (home_s != home_q);
    ev[IRQ_USB] = usb_s != usb_q;
    ev[IRQ_ENC_ERR] = enc_err;
  end
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
    end else begin
      if (i_wr && i_addr == REG_IRQ_MASK) begin
        irq_mask_q <= i_wdata[IRQ_W-1:0];
      end
      if (i_wr && i_addr == REG_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~i_wdata[IRQ_W-1:0]) | ev;
      end else begin
        irq_stat_q <= irq_stat_q | ev;
      end
    end
  end
  assign o_irq = |(irq_stat_q & irq_mask_q);

  // read mux, data one cycle after strobe
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      unique case (i_addr)
        REG_CTRL: o_rdata <= ctrl_q;
        REG_INPUTS: o_rdata <= {26'h0, usb_s, iso_r, iso_l, quad_b, quad_a, home_s};
        REG_ANALOG: o_rdata <= {20'h0, adc_q};
        REG_ENC: o_rdata <= enc_cnt_q;
        REG_IRQ_STAT: o_rdata <= {27'h0, irq_stat_q};
        REG_IRQ_MASK: o_rdata <= {27'h0, irq_mask_q};
        REG_STATUS: o_rdata <= {29'h0, !usb_s, strap_seen_q, restore_q};
        default: o_rdata <= 32'h0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end
endmodule : io_stop_status_logic
`default_nettype wire

// file: sim/io_stop_asserts.sv
// Purpose: port checks for the io/stop/status block
// Assumes: one clock domain, async active-high reset
// Notes: bound onto the block below
`timescale 1ns/1ps
`default_nettype none
module io_stop_asserts
  import io_stop_pkg::*;
#(parameter int unsigned SLOW_CYC = 8, parameter int unsigned FAST_CYC = 4) (
  input wire logic i_ref_clk, // clock
  input wire logic i_reset, // reset
  input wire logic [io_stop_pkg::ADDR_W-1:0] i_addr, // address
  input wire logic [31:0] i_wdata, // wdata
  input wire logic i_wr, // write
  input wire logic i_rd, // read
  input wire logic [31:0] o_rdata, // rdata
  input wire logic [io_stop_pkg::ADC_BITS:0] i_adc_raw, // adc
  input wire logic i_iso_left, // iso left
  input wire logic i_usb_attached, // usb
  input wire io_stop_pkg::motion_cmd_t i_int_cmd, // ramp cmd
  input wire io_stop_pkg::motion_cmd_t o_motor_cmd, // gated cmd
  input wire logic o_can_enable, // can
  input wire logic o_pu_home, // home pull
  input wire logic o_pu_general, // shared pull
  input wire logic o_open_drain_output_oe, // pin enable
  input wire logic o_restore_active, // restore
  input wire io_stop_pkg::led_pair_t o_led // leds
);
  // one domain: clock and reset given once
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // interface, pull-up and output controls, adc saturation
  can_off_a: assert property (i_usb_attached [*4] |-> !o_can_enable)
    else $error("can on with usb");
  pull_ctl_a: assert property (i_wr && i_addr == REG_CTRL |=>
    {o_pu_general, o_pu_home} == $past(i_wdata[1:0])) else $error("pull-ups stale");
  od_ctl_a: assert property (i_wr && i_addr == REG_CTRL |=>
    o_open_drain_output_oe == $past(i_wdata[CTRL_OUT])) else $error("pin enable stale");
  adc_sat_a: assert property (i_rd && i_addr == REG_ANALOG && i_adc_raw[ADC_BITS]
    && $stable(i_adc_raw) |=> o_rdata == 32'h0000_0FFF) else $error("adc not saturated");
  // stepping, restore and indicators
  step_src_a: assert property (o_motor_cmd.step |->
    $past(i_int_cmd.step) || $past(i_iso_left, 3)) else $error("step without source");
  restore_end_a: assert property (i_wr && i_addr == REG_CTRL
    && i_wdata[CTRL_RESTORE_DONE] |=> !o_restore_active) else $error("restore stuck");
  restore_led_a: assert property (o_restore_active && $past(o_restore_active)
    |-> !o_led.red) else $error("red lit in restore");
  boot_led_a: assert property (o_led.red |-> o_led.green) else $error("red alone");
endmodule : io_stop_asserts
bind io_stop_status_logic io_stop_asserts #(.SLOW_CYC(SLOW_CYC), .FAST_CYC(FAST_CYC)) u_chk (.*);
`default_nettype wire

// file: sim/far_side_model.sv
// Purpose: switches, open-drain encoder and external step source
// Assumes: bench sets levels just after a rising edge
// Notes: an encoder line released without pull-up floats
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  input wire logic i_ref_clk, // clock
  input wire logic i_pu, // pull-up on
  input wire logic [1:0] i_lvl, // iso levels
  input wire logic [1:0] i_pull, // encoder pulls low
  output wire logic [1:0] o_iso, // iso pins
  output wire logic [1:0] o_ab // encoder pins
);
  logic t_q = 1'b0;
  // changing level for lines nobody holds
  always @(posedge i_ref_clk) t_q <= ~t_q;
  // stop switches or step/dir source, open-drain encoder
  assign o_iso = i_lvl;
  assign o_ab = ~i_pull & {2{i_pu | t_q}};
endmodule : far_side_model
`default_nettype wire

// file: sim/tb_top.sv
// Purpose: self-checking bench for the io/stop/status block
// Assumes: flash counts shortened to 8 and 4
// Notes: notes are {mask, value}; a monitor pops them
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import io_stop_pkg::*;
  localparam int SC = 8;
  localparam int FC = 4;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, usb = 1'b0, pk = 1'b0, rd_q = 1'b0;
  logic can, puh, pug, oe, rsa, irq, odo;
  logic home = 1'b0, pad = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wd = 32'h0, rdat, obs, seed = 32'h449F3AE6;
  logic [12:0] adc = 13'h0;
  logic [7:0] meas = 8'h0;
  logic [1:0] lvl = 2'b00, pull = 2'b00, iso, ab;
  logic [63:0] q[$];
  motion_cmd_t cmd = 2'b00, mot;
  led_pair_t led;
  int fail_count = 0, num_checks = 0;
  assign obs = pk ? {13'h0, odo, meas, led, rsa, can, oe, pug, puh, mot, irq} : rdat;
  initial forever #12.5 clk = ~clk;
  far_side_model u_far (.i_ref_clk(clk), .i_pu(pug), .i_lvl(lvl), .i_pull(pull), .o_iso(iso),
    .o_ab(ab));
  io_stop_status_logic #(.SLOW_CYC(SC), .FAST_CYC(FC)) DUT (.i_ref_clk(clk), .i_reset(rst),
    .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_adc_raw(adc),
    .i_analog_home_input(home), .i_general_input_a(ab[0]), .i_general_input_b(ab[1]),
    .i_iso_left(iso[0]), .i_iso_right(iso[1]), .i_usb_attached(usb), .i_debug_data_pad(pad),
    .i_int_cmd(cmd), .o_motor_cmd(mot), .o_can_enable(can), .o_pu_home(puh), .o_pu_general(pug),
    .o_open_drain_output(odo), .o_open_drain_output_oe(oe), .o_restore_active(rsa), .o_led(led),
    .o_irq(irq));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    q.push_back({m, e});
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask : rreg
  task automatic ck(input logic [31:0] m, input logic [31:0] e);
    q.push_back({m, e});
    @(posedge clk);
    pk <= 1'b1;
    @(posedge clk);
    pk <= 1'b0;
  endtask : ck
  task automatic flash(input logic [31:0] e);
    logic g;
    int t;
    t = 0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    g = led.green;
    repeat (40) begin
      @(negedge clk);
      t += (led.green !== g);
      g = led.green;
    end
    meas <= t[7:0];
    ck(32'h3FE00, e);
  endtask : flash
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  // each result shown takes the oldest note off the queue
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q || pk) begin
      num_checks++;
      if ((obs & q[0][63:32]) !== q[0][31:0]) begin
        fail_count++;
        $display("ERROR %s exp %h got %h", pk ? "pins" : "rdata", q[0][31:0], obs & q[0][63:32]);
      end
      void'(q.pop_front());
    end
  end
  // watchdog against a hang
  initial begin
    #200_000;
    fail_count++;
    summarize();
  end
  // test sequence
  initial begin
    logic st;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // strap is read only once the synchroniser holds the pad level
    repeat (4) @(posedge clk);
    ck(32'hFF, 32'hD0);
    rreg(REG_STATUS, 32'h7, 32'h7);
    rreg(REG_CTRL, 32'h7FF, CTRL_RESET);
    rreg(4'hF, 32'hFFFFFFFF, 32'h0);
    flash(32'((40 / FC) << 10));
    wreg(REG_CTRL, 32'h402);
    ck(32'h380, 32'h300);
    wreg(REG_CTRL, 32'h302);
    ck(32'h380, 32'h300);
    wreg(REG_CTRL, 32'h102);
    flash(32'((40 / SC) << 10));
    wreg(REG_CTRL, 32'h101);
    ck(32'h18, 32'h08);
    wreg(REG_CTRL, 32'h106);
    pull <= 2'b01;
    repeat (4) @(posedge clk);
    ck(32'h40020, 32'h20);
    rreg(REG_INPUTS, 32'h6, 32'h4);
    $display("leds and pins done");
    for (int i = 0; i < 32; i++) begin
      wreg(REG_CTRL, 32'h102 | {27'h0, i[1:0], 3'h0});
      lvl <= i[3:2];
      cmd <= {1'b1, i[4]};
      st = !(i[0] && i[2] && !i[4]) && !(i[1] && i[3] && i[4]);
      repeat (4) @(posedge clk);
      ck(32'h6, {29'h0, st, i[4], 1'b0});
    end
    cmd <= 2'b00;
    wreg(REG_CTRL, 32'h122);
    for (int j = 0; j < 4; j++) begin
      lvl <= j[1:0];
      repeat (4) @(posedge clk);
      ck(32'h6, {29'h0, j[0], j[1], 1'b0});
    end
    $display("stops done");
    // quadrature count, illegal double change and home edge
    pull <= 2'b11;
    repeat (4) @(posedge clk);
    wreg(REG_CTRL, 32'h1C2);
    for (int k = 0; k < 4; k++) begin
      pull <= {pull[0], ~pull[1]};
      repeat (4) @(posedge clk);
    end
    rreg(REG_ENC, 32'hFFFFFFFF, 32'h4);
    pull <= ~pull;
    home <= 1'b1;
    repeat (4) @(posedge clk);
    rreg(REG_ENC, 32'hFFFFFFFF, 32'h4);
    rreg(REG_IRQ_STAT, 32'h14, 32'h14);
    $display("encoder and home done");
    repeat (6) begin
      seed = lfsr(seed);
      adc <= seed[12:0];
      repeat (2) @(posedge clk);
      rreg(REG_ANALOG, 32'hFFFFFFFF, seed[12] ? 32'h0000_0FFF : {20'h0, seed[11:0]});
    end
    adc <= 13'h1ABC;
    repeat (2) @(posedge clk);
    rreg(REG_ANALOG, 32'hFFFFFFFF, 32'h0000_0FFF);
    usb <= 1'b1;
    repeat (4) @(posedge clk);
    ck(32'h41, 32'h0);
    wreg(REG_IRQ_MASK, 32'h8);
    ck(32'h1, 32'h1);
    rreg(REG_IRQ_STAT, 32'h8, 32'h8);
    usb <= 1'b0;
    repeat (4) @(posedge clk);
    wreg(REG_IRQ_STAT, 32'h1F);
    ck(32'h41, 32'h40);
    $display("adc and usb done");
    // second reset with the pads open: no restore may start
    pad <= 1'b1;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rreg(REG_STATUS, 32'h3, 32'h2);
    ck(32'h80, 32'h0);
    $display("reset with pads open done");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
